// ---- logic/wpe_defines.svh ----
// timing and arithmetic constants for the power and energy accumulator
`ifndef WPE_DEFINES_SVH
`define WPE_DEFINES_SVH
`define WPE_CLK_HZ 50000000
`define WPE_SAMPLE_HZ 10240
`define WPE_WIN_LEN 1024
`define WPE_MEAS_PER_SEC 20
`define WPE_PPS_TIMEOUT_MS 1500
`define WPE_PPS_TOL_CYC 500000
`define WPE_FRAC_BITS 14
`define WPE_LOSS_SHIFT 16
`endif

// ---- logic/wpe_pkg.sv ----
// types shared by the power and energy accumulator
package wpe_pkg;
    typedef logic signed [15:0] sample_t;
    typedef logic signed [47:0] acc_t;
    typedef logic [63:0]        energy_t;
    typedef struct packed { sample_t re; sample_t im; } cplx_t;
    typedef struct packed {
        sample_t [2:0] volt;
        sample_t [2:0] curr;
    } adc_frame_t;
    typedef struct packed {
        sample_t cuW;
        sample_t cuVar;
        sample_t feW;
        sample_t feVar;
        logic    cuEn;
        logic    feEn;
    } loss_cfg_t;
    typedef struct packed { acc_t p; acc_t q; acc_t vv; acc_t ii; } sums_t;
    typedef struct packed {
        energy_t whDel;
        energy_t whRec;
        energy_t varhDel;
        energy_t varhRec;
    } energy_set_t;
    typedef struct packed { acc_t watts; acc_t vars; } power_t;
    typedef struct packed { logic [28:0] volt; logic [28:0] curr; } rms_t;
    typedef struct packed {
        logic [2:0]         ppsSync;
        logic               ppsLevel;
        logic               utcLocked;
        logic [27:0]        ppsAge;
        logic [25:0]        secCnt;
        logic [25:0]        modulus;
        logic [25:0]        phaseAcc;
        logic [31:0]        rtcSec;
        logic               convStart;
        logic [8:0]         halfCnt;
        sample_t [2:0]      prevV;
        sample_t [2:0]      prevI;
        sums_t [2:0]        half;
        sums_t [2:0]        prevHalf;
        sums_t [2:0]        win;
        logic               winValid;
        energy_set_t [2:0]  acc;
        energy_set_t [2:0]  stored;
        logic               storeStrobe;
        logic [15:0]        intCnt;
        logic [4:0]         measInSec;
        power_t [2:0]       sumPw;
        power_t [2:0]       avgPw;
        power_t [2:0]       reply;
        rms_t [2:0]         sumRms;
        rms_t [2:0]         avgRms;
        logic               secStrobe;
        logic               powerAck;
    } wpe_state_t;
endpackage

// ---- logic/windowed_power_energy_accumulator.sv ----
// windowed power, energy and rms measurement core with disciplined timebase
`timescale 1ns/1ns
`include "wpe_defines.svh"
module windowed_power_energy_accumulator
    import wpe_pkg::*;
#(
    parameter logic [27:0] PPS_TIMEOUT_CYC =
        28'(`WPE_CLK_HZ / 1000 * `WPE_PPS_TIMEOUT_MS),
    parameter logic [25:0] NOM_CYC = 26'(`WPE_CLK_HZ)
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                reset_n,
    // timing reference pin
    input  wire logic                ppsIn,
    // converters
    output logic                     convStart,
    input  wire logic                adcValid,
    input  wire adc_frame_t          adcFrame,
    // correction setup
    input  wire cplx_t               voltageTransformerFactor,
    input  wire cplx_t               currentTransformerFactor,
    input  wire loss_cfg_t           lossCfg,
    input  wire logic [15:0]         regIntervalMeas,
    // host request
    input  wire logic                powerReq,
    output logic                     powerAck,
    output power_t [2:0]             powerReply,
    // results
    output logic                     secStrobe,
    output power_t [2:0]             avgPower,
    output rms_t [2:0]               avgRms,
    output logic                     storeStrobe,
    output energy_set_t [2:0]        storedEnergy,
    // time status
    output logic                     utcLocked,
    output logic [31:0]              rtcSeconds
);
    localparam logic [25:0] SAMPLE_INC = 26'(`WPE_SAMPLE_HZ);
    localparam int          HALF_LEN   = `WPE_WIN_LEN / 2;
    localparam logic [8:0]  HALF_LAST  = 9'(HALF_LEN - 1);
    localparam logic [4:0]  SEC_LAST   = 5'(`WPE_MEAS_PER_SEC - 1);

    wpe_state_t         s_r;
    wpe_state_t         s_nxt;
    logic               ppsAgree;
    logic               ppsRise;
    logic               secInTol;
    logic [15:0]        ivl;
    logic               storeNow;
    logic signed [31:0] kRe;
    logic signed [31:0] kIm;
    acc_t [2:0]         pc;
    acc_t [2:0]         qc;
    logic [2:0][47:0]   pMag;
    logic [2:0][47:0]   qMag;
    logic [2:0][23:0]   vRt;
    logic [2:0][23:0]   iRt;

    function automatic logic signed [31:0] mul16(input sample_t a,
                                                  input sample_t b);
        mul16 = a * b;
    endfunction

    function automatic sums_t addSums(input sums_t a, input sums_t b);
        addSums.p  = a.p + b.p;
        addSums.q  = a.q + b.q;
        addSums.vv = a.vv + b.vv;
        addSums.ii = a.ii + b.ii;
    endfunction

    // bitwise root; wide but only evaluated on registered window sums
    function automatic logic [23:0] isqrt(input logic [47:0] x);
        logic [23:0] r;
        logic [23:0] t;
        r = '0;
        for (int b = 23; b >= 0; b--) begin
            t = r | (24'h1 << b);
            if (48'(t) * 48'(t) <= x) begin
                r = t;
            end
        end
        return r;
    endfunction

    // only the second and third stages are compared
    assign ppsAgree = s_r.ppsSync[1] == s_r.ppsSync[2];
    assign ppsRise  = ppsAgree && s_r.ppsSync[1] && !s_r.ppsLevel;
    assign secInTol = s_r.secCnt > NOM_CYC - 26'(`WPE_PPS_TOL_CYC) &&
                      s_r.secCnt < NOM_CYC + 26'(`WPE_PPS_TOL_CYC);
    // zero would end every interval as well, so it acts as one
    assign ivl      = (regIntervalMeas == 16'h0) ? 16'h1 : regIntervalMeas;
    assign storeNow = s_r.winValid &&
                      ({1'b0, s_r.intCnt} + 17'h1 >= {1'b0, ivl});

    // combined factor is the complex product of both transformers
    assign kRe = (voltageTransformerFactor.re * currentTransformerFactor.re -
                  voltageTransformerFactor.im * currentTransformerFactor.im)
                 >>> `WPE_FRAC_BITS;
    assign kIm = (voltageTransformerFactor.re * currentTransformerFactor.im +
                  voltageTransformerFactor.im * currentTransformerFactor.re)
                 >>> `WPE_FRAC_BITS;

    for (genvar g = 0; g < 3; g++) begin : g_phase
        logic signed [79:0] pFull;
        logic signed [79:0] qFull;
        logic signed [63:0] cuP;
        logic signed [63:0] cuQ;
        logic signed [63:0] feP;
        logic signed [63:0] feQ;
        assign pFull = s_r.win[g].p * kRe - s_r.win[g].q * kIm;
        assign qFull = s_r.win[g].p * kIm + s_r.win[g].q * kRe;
        assign cuP = s_r.win[g].ii * lossCfg.cuW;
        assign cuQ = s_r.win[g].ii * lossCfg.cuVar;
        assign feP = s_r.win[g].vv * lossCfg.feW;
        assign feQ = s_r.win[g].vv * lossCfg.feVar;
        assign pc[g] = acc_t'(pFull >>> `WPE_FRAC_BITS)
            - (lossCfg.cuEn ? acc_t'(cuP >>> `WPE_LOSS_SHIFT) : '0)
            - (lossCfg.feEn ? acc_t'(feP >>> `WPE_LOSS_SHIFT) : '0);
        assign qc[g] = acc_t'(qFull >>> `WPE_FRAC_BITS)
            - (lossCfg.cuEn ? acc_t'(cuQ >>> `WPE_LOSS_SHIFT) : '0)
            - (lossCfg.feEn ? acc_t'(feQ >>> `WPE_LOSS_SHIFT) : '0);
        assign pMag[g] = pc[g][47] ? -pc[g] : pc[g];
        assign qMag[g] = qc[g][47] ? -qc[g] : qc[g];
        assign vRt[g]  = isqrt(s_r.win[g].vv);
        assign iRt[g]  = isqrt(s_r.win[g].ii);
    end

    always_comb begin
        sums_t       h;
        energy_set_t e;
        power_t      pw;
        rms_t        rm;
        h  = '0;
        e  = '0;
        pw = '0;
        rm = '0;
        s_nxt = s_r;
        s_nxt.convStart   = 1'b0;
        s_nxt.winValid    = 1'b0;
        s_nxt.storeStrobe = 1'b0;
        s_nxt.secStrobe   = 1'b0;
        s_nxt.powerAck    = 1'b0;
        s_nxt.ppsSync = {s_r.ppsSync[1:0], ppsIn};
        if (ppsAgree) begin
            s_nxt.ppsLevel = s_r.ppsSync[1];
        end
        s_nxt.secCnt = s_r.secCnt + 26'h1;
        if (s_r.ppsAge < PPS_TIMEOUT_CYC) begin
            s_nxt.ppsAge = s_r.ppsAge + 28'h1;
        end else begin
            s_nxt.utcLocked = 1'b0;
        end
        // fractional divider keeps the mean rate exact while the modulus is at least SAMPLE_INC
        if (s_r.phaseAcc + SAMPLE_INC >= s_r.modulus) begin
            s_nxt.phaseAcc  = s_r.phaseAcc + SAMPLE_INC - s_r.modulus;
            s_nxt.convStart = 1'b1;
        end else begin
            s_nxt.phaseAcc = s_r.phaseAcc + SAMPLE_INC;
        end
        if (!s_r.utcLocked && s_nxt.secCnt >= s_r.modulus) begin
            s_nxt.secCnt = '0;
            s_nxt.rtcSec = s_r.rtcSec + 32'h1;
        end
        if (adcValid) begin
            for (int ph = 0; ph < 3; ph++) begin
                h = s_r.half[ph];
                h.p  = h.p + acc_t'(mul16(adcFrame.volt[ph],
                                          adcFrame.curr[ph]));
                // quadrature cross term stands in for reactive power
                h.q  = h.q + acc_t'(mul16(s_r.prevV[ph], adcFrame.curr[ph]))
                     - acc_t'(mul16(adcFrame.volt[ph], s_r.prevI[ph]));
                h.vv = h.vv + acc_t'(mul16(adcFrame.volt[ph],
                                           adcFrame.volt[ph]));
                h.ii = h.ii + acc_t'(mul16(adcFrame.curr[ph],
                                           adcFrame.curr[ph]));
                s_nxt.prevV[ph] = adcFrame.volt[ph];
                s_nxt.prevI[ph] = adcFrame.curr[ph];
                if (s_r.halfCnt == HALF_LAST) begin
                    s_nxt.win[ph]      = addSums(s_r.prevHalf[ph], h);
                    s_nxt.prevHalf[ph] = h;
                    s_nxt.half[ph]     = '0;
                end else begin
                    s_nxt.half[ph] = h;
                end
            end
            if (s_r.halfCnt == HALF_LAST) begin
                s_nxt.halfCnt  = '0;
                s_nxt.winValid = 1'b1;
            end else begin
                s_nxt.halfCnt = s_r.halfCnt + 9'h1;
            end
        end
        if (s_r.winValid) begin
            for (int ph = 0; ph < 3; ph++) begin
                e = s_r.acc[ph];
                if (!pc[ph][47]) begin
                    e.whDel = e.whDel + energy_t'(pMag[ph]);
                end else begin
                    e.whRec = e.whRec + energy_t'(pMag[ph]);
                end
                if (!qc[ph][47]) begin
                    e.varhDel = e.varhDel + energy_t'(qMag[ph]);
                end else begin
                    e.varhRec = e.varhRec + energy_t'(qMag[ph]);
                end
                if (storeNow) begin
                    s_nxt.stored[ph] = e;
                    s_nxt.acc[ph]    = '0;
                end else begin
                    s_nxt.acc[ph] = e;
                end
                pw.watts = s_r.sumPw[ph].watts + pc[ph];
                pw.vars  = s_r.sumPw[ph].vars + qc[ph];
                rm.volt  = s_r.sumRms[ph].volt + 29'(vRt[ph]);
                rm.curr  = s_r.sumRms[ph].curr + 29'(iRt[ph]);
                if (s_r.measInSec == SEC_LAST) begin
                    s_nxt.avgPw[ph].watts =
                        acc_t'(pw.watts / `WPE_MEAS_PER_SEC);
                    s_nxt.avgPw[ph].vars =
                        acc_t'(pw.vars / `WPE_MEAS_PER_SEC);
                    s_nxt.avgRms[ph].volt =
                        29'(rm.volt / `WPE_MEAS_PER_SEC);
                    s_nxt.avgRms[ph].curr =
                        29'(rm.curr / `WPE_MEAS_PER_SEC);
                    s_nxt.sumPw[ph]  = '0;
                    s_nxt.sumRms[ph] = '0;
                end else begin
                    s_nxt.sumPw[ph]  = pw;
                    s_nxt.sumRms[ph] = rm;
                end
            end
            s_nxt.intCnt      = storeNow ? 16'h0 : s_r.intCnt + 16'h1;
            s_nxt.storeStrobe = storeNow;
            if (s_r.measInSec == SEC_LAST) begin
                s_nxt.measInSec = '0;
                s_nxt.secStrobe = 1'b1;
            end else begin
                s_nxt.measInSec = s_r.measInSec + 5'h1;
            end
        end
        if (powerReq) begin
            s_nxt.reply    = s_r.avgPw;
            s_nxt.powerAck = 1'b1;
        end
        // a partial half block is dropped so windows start on the second
        if (ppsRise) begin
            if (s_r.utcLocked && secInTol) begin
                s_nxt.modulus = s_r.secCnt + 26'h1;
            end
            s_nxt.utcLocked = 1'b1;
            s_nxt.ppsAge    = '0;
            s_nxt.secCnt    = '0;
            s_nxt.phaseAcc  = '0;
            s_nxt.convStart = 1'b1;
            s_nxt.rtcSec    = s_r.rtcSec + 32'h1;
            s_nxt.halfCnt   = '0;
            s_nxt.half      = '0;
            s_nxt.measInSec = '0;
            s_nxt.sumPw     = '0;
            s_nxt.sumRms    = '0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_r         <= '0;
            s_r.modulus <= NOM_CYC;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign convStart    = s_r.convStart;
    assign powerAck     = s_r.powerAck;
    assign powerReply   = s_r.reply;
    assign secStrobe    = s_r.secStrobe;
    assign avgPower     = s_r.avgPw;
    assign avgRms       = s_r.avgRms;
    assign storeStrobe  = s_r.storeStrobe;
    assign storedEnergy = s_r.stored;
    assign utcLocked    = s_r.utcLocked;
    assign rtcSeconds   = s_r.rtcSec;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // a reference edge may realign right after a divider strobe
    a_conv_single: assert property (
        s_r.convStart && !ppsRise |=> !s_r.convStart)
        else $error("sample strobe longer than one cycle");
    a_half_window: assert property (
        s_r.winValid |-> $past(s_r.halfCnt) == HALF_LAST)
        else $error("window closed off a half boundary");
    a_quad_split: assert property (
        s_r.winValid && !pc[0][47] && !storeNow |=>
        s_r.acc[0].whRec == $past(s_r.acc[0].whRec) &&
        s_r.acc[0].whDel == $past(s_r.acc[0].whDel + energy_t'(pMag[0])))
        else $error("delivered energy sorted wrongly");
    a_store_clear: assert property (
        storeNow |=> s_r.storeStrobe && s_r.acc[0] == '0)
        else $error("accumulators not cleared at store");
    a_store_edge: assert property (
        s_r.storeStrobe |-> $past(s_r.winValid))
        else $error("store not on a measurement boundary");
    a_sec_rate: assert property (
        s_r.secStrobe |-> $past(s_r.measInSec) == SEC_LAST)
        else $error("second mean not after twenty measurements");
    a_reply_data: assert property (
        powerReq |=> s_r.powerAck && s_r.reply == $past(s_r.avgPw))
        else $error("power reply wrong or late");
    a_pps_align: assert property (
        ppsRise |=> s_r.convStart && s_r.phaseAcc == 26'h0 ##1 !s_r.convStart)
        else $error("sample clock not aligned to reference");
    a_disc_mod: assert property (
        ppsRise && s_r.utcLocked && secInTol |=>
        s_r.modulus == $past(s_r.secCnt) + 26'h1)
        else $error("timebase not disciplined");
    a_lock_loss: assert property (
        s_r.ppsAge >= PPS_TIMEOUT_CYC && !ppsRise |=> !s_r.utcLocked)
        else $error("lock kept without reference");

    c_window: cover property (s_r.winValid);
    c_store: cover property (s_r.storeStrobe);
    c_second: cover property (s_r.secStrobe ##[1:40] powerReq);
    c_pps: cover property (ppsRise ##1 s_r.utcLocked);
endmodule // windowed_power_energy_accumulator

// ---- verification/wpe_adc_model.sv ----
// behavioural model of the six per-channel converters
`timescale 1ns/1ns
module wpe_adc_model
    import wpe_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // conversion control
    input  wire logic       convStart,
    input  wire logic       slow,
    input  wire adc_frame_t analogIn,
    // converter results
    output logic            adcValid,
    output adc_frame_t      adcFrame
);
    logic [1:0] waitCnt;
    logic       busy;
    adc_frame_t held;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            waitCnt <= 2'h0;
            held <= '0;
            adcValid <= 1'b0;
            adcFrame <= '0;
        end else begin
            adcValid <= 1'b0;
            // idle bus shows inverted stale data, never a lucky match
            adcFrame <= ~held;
            if (convStart) begin
                // all six channels latched on one start
                held <= analogIn;
                waitCnt <= slow ? 2'h2 : 2'h0;
                busy <= 1'b1;
            end else if (busy && waitCnt != 2'h0) begin
                waitCnt <= waitCnt - 2'h1;
            end else if (busy) begin
                adcValid <= 1'b1;
                adcFrame <= held;
                busy <= 1'b0;
            end
        end
    end
endmodule // wpe_adc_model

// ---- verification/windowed_power_energy_accumulator_test.sv ----
// self-checking bench for the power and energy accumulator
`timescale 1ns/1ns
module windowed_power_energy_accumulator_test
    import wpe_pkg::*;
;
    localparam int NOM  = 40960;
    localparam int CONV = NOM / 10240;
    localparam int NINT = 3;
    typedef power_t [2:0] reply_t;

    logic              mclk = 1'b0;
    logic              reset_n = 1'b0;
    logic              ppsIn = 1'b0;
    logic              powerReq = 1'b0;
    logic              slow = 1'b0;
    logic              convStart, adcValid, powerAck, secStrobe;
    logic              storeStrobe, utcLocked, reqAtEdge = 1'b0;
    logic              checkOn = 1'b0;
    logic [31:0]       rtcSeconds;
    adc_frame_t        adcFrame;
    adc_frame_t        analogIn = '0;
    cplx_t             vtf = '{16'sh4000, 16'sh0000};
    cplx_t             ctf = '{16'sh2000, 16'sh0000};
    // iron terms nonzero but disabled: must not leak in
    loss_cfg_t         lossCfg = '{16'sh4000, 16'sh0000, 16'sh2000,
                                   16'sh0064, 1'b1, 1'b0};
    power_t [2:0]      powerReply, avgPower, expPw;
    rms_t [2:0]        avgRms, expRms;
    energy_set_t [2:0] storedEnergy, expEn;
    reply_t            replyQ[$];
    int                miscompares = 0, checks = 0, cyc = 0, k;
    int                nSec = 0, nStore = 0, lastConv = 0;
    int                lastSec = 0, lastStore = 0;
    longint            v, iv, pw, comb;

    always #10 mclk = ~mclk;

    windowed_power_energy_accumulator #(
        .PPS_TIMEOUT_CYC(28'h00007d0),
        .NOM_CYC        (26'h000a000)
    ) i_dut (
        .mclk(mclk), .reset_n(reset_n), .ppsIn(ppsIn),
        .convStart(convStart), .adcValid(adcValid), .adcFrame(adcFrame),
        .voltageTransformerFactor(vtf), .currentTransformerFactor(ctf),
        .lossCfg(lossCfg), .regIntervalMeas(16'(NINT)),
        .powerReq(powerReq), .powerAck(powerAck), .powerReply(powerReply),
        .secStrobe(secStrobe), .avgPower(avgPower), .avgRms(avgRms),
        .storeStrobe(storeStrobe), .storedEnergy(storedEnergy),
        .utcLocked(utcLocked), .rtcSeconds(rtcSeconds)
    );

    wpe_adc_model i_adc (
        .mclk(mclk), .reset_n(reset_n), .convStart(convStart),
        .slow(slow), .analogIn(analogIn), .adcValid(adcValid),
        .adcFrame(adcFrame)
    );

    task automatic check(input logic [767:0] seen, input logic [767:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic summarize;
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic expire;
        miscompares++;
        summarize();
    endtask

    // strobe held high for n cycles, one expected reply per cycle
    task automatic request(input int n, input reply_t exp);
        powerReq = 1'b1;
        repeat (n) begin
            replyQ.push_back(exp);
            @(negedge mclk);
        end
        powerReq = 1'b0;
    endtask

    always @(posedge mclk) reqAtEdge <= powerReq;

    always @(negedge mclk) begin
        if (reset_n) begin
            cyc++;
            // ack follows the edge that took the request
            if (reqAtEdge || powerAck) check(powerAck, reqAtEdge);
            if (powerAck && replyQ.size() > 0) begin
                check(powerReply, replyQ.pop_front());
            end
            if (convStart && checkOn && lastConv > 0) begin
                check(cyc - lastConv, CONV);
            end
            if (convStart) lastConv = cyc;
            if (secStrobe) begin
                nSec++;
                // first second holds the half-empty first window
                if (checkOn && nSec >= 2) begin
                    check(cyc - lastSec, NOM);
                    check(avgPower, expPw);
                    check(avgRms, expRms);
                end
                lastSec = cyc;
            end
            if (storeStrobe) begin
                nStore++;
                if (checkOn && nStore >= 2) begin
                    check(cyc - lastStore, NINT * 512 * CONV);
                    check(storedEnergy, expEn);
                end
                lastStore = cyc;
            end
        end
    end

    initial begin
        void'($urandom(98798));
        v = 3 + $urandom % 118;
        slow = 1'($urandom % 2);
        comb = (longint'(vtf.re) * ctf.re) >>> 14;
        // phase 0 delivers, phase 1 receives, phase 2 carries no current
        for (k = 0; k < 3; k++) begin
            iv = (k == 0) ? 4 : (k == 1) ? -4 : 0;
            analogIn.volt[k] = 16'(v);
            analogIn.curr[k] = 16'(iv);
            pw = ((1024 * v * iv * comb) >>> 14)
                 - ((longint'(lossCfg.cuW) * 1024 * iv * iv) >>> 16);
            expPw[k] = '{48'(pw), 48'h0};
            expRms[k] = '{29'(32 * v), 29'((iv < 0) ? -32 * iv : 32 * iv)};
            expEn[k] = '{64'((pw >= 0) ? NINT * pw : 0),
                         64'((pw < 0) ? -NINT * pw : 0), 64'h0, 64'h0};
        end
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        checkOn = 1'b1;
        repeat (20) @(negedge mclk);
        request(1, '0);
        for (k = 0; k < 2 * NOM + NOM / 4 && nSec < 2; k++) @(negedge mclk);
        if (nSec < 2) expire();
        repeat ($urandom % 8 + 1) @(negedge mclk);
        request(2, expPw);
        repeat (1000) @(negedge mclk);
        check(rtcSeconds, 32'h2);
        check(utcLocked, 1'b0);
        // a pps edge restarts counting, so spacing checks stop here
        checkOn = 1'b0;
        slow = ~slow;
        ppsIn = 1'b1;
        for (k = 1; k <= 8 && !(convStart && utcLocked); k++) @(negedge mclk);
        check(k - 1, 4);
        check(rtcSeconds, 32'h3);
        repeat (50) @(negedge mclk);
        ppsIn = 1'b0;
        repeat (1900) @(negedge mclk);
        check(utcLocked, 1'b1);
        for (k = 0; k < 200 && utcLocked; k++) @(negedge mclk);
        check(utcLocked, 1'b0);
        summarize();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        expire();
    end
endmodule // windowed_power_energy_accumulator_test
